// >>> logic/disk_arb_cfg.svh
/*
 * Offsets, field positions, reset values and counts of the dual disk
 * command arbiter. Assumes inclusion by bare name; definitions only.
 */
`ifndef DISK_ARB_CFG_SVH
`define DISK_ARB_CFG_SVH

// --------------------------------------------------------------------
// Scratch RAM layout (word indexes)
// --------------------------------------------------------------------
`define CART_CSR_IDX 4'h0
`define FLOP_CSR_IDX 4'h4
`define DEV_WIN_WORDS 4'h4
`define BOOT_WIN_WORDS 4'h8

// --------------------------------------------------------------------
// Command and status word fields
// --------------------------------------------------------------------
`define CART_READY_BIT 4'd7
`define FLOP_DONE_BIT 4'd5
`define IRQ_ENABLE_BIT 4'd6

// --------------------------------------------------------------------
// Control space: byte offsets 0x800..0x81c, word index in [4:2]
// --------------------------------------------------------------------
`define CTRL_SPACE_TAG 7'h40
`define CTRL_CART_BASE 3'h0
`define CTRL_FLOP_BASE 3'h1
`define CTRL_BOOT_BASE 3'h2
`define CTRL_IRQ_CFG 3'h3
`define CTRL_IRQ_STATUS 3'h4
`define CTRL_IRQ_CLEAR 3'h5
`define CTRL_IRQ_ENABLE 3'h6
`define IRQ_LEVEL_LSB 0
`define IRQ_VECTOR_LSB 16
`define STAT_EXEC_CART_BIT 8
`define STAT_EXEC_FLOP_BIT 9
`define STAT_QUEUE_BIT 10
`define IRQ_CART 0
`define IRQ_FLOP 1

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define CART_BASE_RST 5'h01
`define FLOP_BASE_RST 5'h02
`define BOOT_BASE_RST 5'h03
`define IRQ_LEVEL_RST 3'h4
`define IRQ_VECTOR_RST 9'h070
`define WPTR_FIRST 2'h1
`define WPTR_LAST 2'h3
`define SHIFT_LAST 2'h3

`endif

// >>> logic/disk_arb_pkg.sv
/*
 * Types of the dual disk command arbiter: state encodings and the
 * packed state records. Assumes disk_arb_cfg.svh is on the include path.
 */
package disk_arb_pkg;

    typedef logic [15:0] word_t;

    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_CART = 3'b010,
        EX_FLOP = 3'b100
    } exec_e;

    typedef enum logic [2:0] {
        XF_IDLE = 3'b001,
        XF_SHIFT = 3'b010,
        XF_STORE = 3'b100
    } xfer_e;

    typedef struct packed {
        word_t word;
    } nib_buf_s;

    typedef struct packed {
        word_t [15:0] ram;
        exec_e exec;
        logic qvalid;
        logic qfloppy;
        word_t qword;
        logic cmd_valid;
        logic cmd_floppy;
        word_t cmd_word;
        logic [4:0] cart_base;
        logic [4:0] flop_base;
        logic [4:0] boot_base;
        logic [2:0] irq_level;
        logic [8:0] irq_vec_cfg;
        logic [8:0] irq_vector;
        logic [1:0] irq_status;
        logic [1:0] irq_en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic hold_full;
        word_t hold_word;
        logic dbus_ready;
        xfer_e xfer;
        logic [1:0] shcnt;
        logic xfloppy;
        logic [1:0] wptr;
    } arb_s;

endpackage : disk_arb_pkg

// >>> logic/nibble_buffer.sv
/*
 * One 16-bit data buffer register: parallel load or nibble shift.
 * Assumes load and shift are never asserted together by the user.
 */
`timescale 1ns/1ps
module nibble_buffer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [15:0] load_word,
    input wire logic shift,
    input wire logic [3:0] nib_in,
    output logic [15:0] word,
    output logic [3:0] nib_out
);
    disk_arb_pkg::nib_buf_s b_q;
    disk_arb_pkg::nib_buf_s b_d;

    always_comb begin
        b_d = b_q;
        if (load) begin
            b_d.word = load_word;
        end else if (shift) begin
            b_d.word = {b_q.word[11:0], nib_in};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    assign word = b_q.word;
    assign nib_out = b_q.word[15:12];
endmodule : nibble_buffer

// >>> logic/dual_disk_command_arbiter.sv
/*
 * Dual disk command arbiter: two emulated disk personalities share one
 * controller. Host reaches it over APB, the controller over a command
 * handshake and a word handshake. Assumes one clock and a synchronous
 * host initialise on rst_n; the controller takes a command before it
 * reports completion.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "disk_arb_cfg.svh"
module dual_disk_command_arbiter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic cmd_floppy,
    output logic [15:0] cmd_word,
    input wire logic ctrl_done,
    input wire logic dbus_valid,
    input wire logic [15:0] dbus_word,
    output logic dbus_ready,
    output logic irq,
    output logic [2:0] irq_level,
    input wire logic irq_ack,
    output logic [8:0] irq_vector
);
    disk_arb_pkg::arb_s s_q;
    disk_arb_pkg::arb_s s_d;
    logic [1:0] dec_kind;
    logic [3:0] dec_idx;
    logic is_csr;
    logic csr_floppy;
    logic busy_for;
    logic setup;
    logic access;
    logic b_load;
    logic b_shift;
    logic [15:0] a_word;
    logic [15:0] b_word;
    logic [3:0] b_nib;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Kind 2'b01 is scratch RAM, 2'b10 control space, 2'b00 unmapped.
    function automatic logic [5:0] decode(input logic [11:0] a,
                                          input logic [4:0] cb,
                                          input logic [4:0] fb,
                                          input logic [4:0] bb);
        logic [5:0] r;
        r = 6'h00;
        if (a[11:5] == `CTRL_SPACE_TAG) begin
            r = {2'b10, 1'b0, a[4:2]};
        end else if (!a[11] && a[10:6] == cb && a[5:2] < `DEV_WIN_WORDS) begin
            r = {2'b01, `CART_CSR_IDX + {2'b00, a[3:2]}};
        end else if (!a[11] && a[10:6] == fb && a[5:2] < `DEV_WIN_WORDS) begin
            r = {2'b01, `FLOP_CSR_IDX + {2'b00, a[3:2]}};
        end else if (!a[11] && a[10:6] == bb && a[5:2] < `BOOT_WIN_WORDS) begin
            r = {2'b01, 1'b1, a[4:2]};
        end
        return r;
    endfunction : decode

    function automatic logic [3:0] csr_of(input logic floppy);
        return floppy ? `FLOP_CSR_IDX : `CART_CSR_IDX;
    endfunction : csr_of

    function automatic logic [3:0] flag_of(input logic floppy);
        return floppy ? `FLOP_DONE_BIT : `CART_READY_BIT;
    endfunction : flag_of

    assign {dec_kind, dec_idx} = decode(paddr, s_q.cart_base,
                                        s_q.flop_base, s_q.boot_base);
    assign is_csr = dec_kind == 2'b01 &&
                    (dec_idx == `CART_CSR_IDX || dec_idx == `FLOP_CSR_IDX);
    assign csr_floppy = dec_idx == `FLOP_CSR_IDX;
    // Busy when this personality runs, or anything runs and queue is full
    assign busy_for = s_q.exec != disk_arb_pkg::EX_IDLE &&
                      (s_q.qvalid || (s_q.exec == disk_arb_pkg::EX_FLOP)
                       == csr_floppy);
    assign setup = psel && !penable;
    assign access = psel && penable && s_q.pready;

    // ----------------------------------------------------------------
    // Data buffers: B faces the drive bus, A faces the scratch RAM
    // ----------------------------------------------------------------
    nibble_buffer buf_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(1'b0),
        .load_word(16'h0000),
        .shift(b_shift),
        .nib_in(b_nib),
        .word(a_word),
        .nib_out()
    );

    // B rotates into itself so it stays intact while A fills
    nibble_buffer buf_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(b_load),
        .load_word(s_q.hold_word),
        .shift(b_shift),
        .nib_in(b_nib),
        .word(b_word),
        .nib_out(b_nib)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] irq_set;
        logic [1:0] irq_clr;
        logic tgt;
        disk_arb_pkg::word_t wval;
        irq_set = 2'b00;
        irq_clr = 2'b00;
        tgt = 1'b0;
        wval = 16'h0000;
        s_d = s_q;
        b_load = 1'b0;
        b_shift = 1'b0;
        s_d.pready = 1'b0;
        if (s_q.cmd_valid && cmd_ready) begin
            s_d.cmd_valid = 1'b0;
        end
        // Completion first, so a command in the same cycle sees the new state
        if (ctrl_done && s_q.exec != disk_arb_pkg::EX_IDLE) begin
            tgt = s_q.exec == disk_arb_pkg::EX_FLOP;
            s_d.ram[csr_of(tgt)][flag_of(tgt)] = 1'b1;
            if (s_q.ram[csr_of(tgt)][`IRQ_ENABLE_BIT]) begin
                irq_set[tgt] = 1'b1;
            end
            s_d.exec = disk_arb_pkg::EX_IDLE;
            s_d.wptr = `WPTR_FIRST;
            if (s_q.qvalid) begin
                s_d.qvalid = 1'b0;
                s_d.exec = s_q.qfloppy ? disk_arb_pkg::EX_FLOP
                                       : disk_arb_pkg::EX_CART;
                s_d.cmd_valid = 1'b1;
                s_d.cmd_floppy = s_q.qfloppy;
                s_d.cmd_word = s_q.qword;
            end
        end
        // Word path: holding register -> B -> A by nibbles -> RAM
        unique case (s_q.xfer)
            disk_arb_pkg::XF_IDLE: begin
                if (s_q.hold_full) begin
                    b_load = 1'b1;
                    s_d.hold_full = 1'b0;
                    s_d.shcnt = 2'b00;
                    s_d.xfloppy = s_q.exec == disk_arb_pkg::EX_FLOP;
                    s_d.xfer = disk_arb_pkg::XF_SHIFT;
                end
            end
            disk_arb_pkg::XF_SHIFT: begin
                b_shift = 1'b1;
                s_d.shcnt = s_q.shcnt + 2'b01;
                if (s_q.shcnt == `SHIFT_LAST) begin
                    s_d.xfer = disk_arb_pkg::XF_STORE;
                end
            end
            disk_arb_pkg::XF_STORE: begin
                s_d.ram[csr_of(s_q.xfloppy) + {2'b00, s_q.wptr}] = a_word;
                s_d.wptr = s_q.wptr == `WPTR_LAST ? `WPTR_FIRST
                                                  : s_q.wptr + 2'b01;
                s_d.xfer = disk_arb_pkg::XF_IDLE;
            end
        endcase
        if (dbus_valid && s_q.dbus_ready) begin
            s_d.hold_full = 1'b1;
            s_d.hold_word = dbus_word;
        end
        // APB: answer is prepared in the setup cycle, taken next edge
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            s_d.pslverr = dec_kind == 2'b00 ||
                          (dec_kind == 2'b10 && dec_idx == 4'h7) ||
                          (pwrite && is_csr && busy_for);
            if (dec_kind == 2'b01) begin
                s_d.prdata = {16'h0000, s_q.ram[dec_idx]};
            end else if (dec_kind == 2'b10) begin
                unique case (dec_idx[2:0])
                    `CTRL_CART_BASE: s_d.prdata = {27'h0, s_q.cart_base};
                    `CTRL_FLOP_BASE: s_d.prdata = {27'h0, s_q.flop_base};
                    `CTRL_BOOT_BASE: s_d.prdata = {27'h0, s_q.boot_base};
                    `CTRL_IRQ_CFG: begin
                        s_d.prdata[`IRQ_LEVEL_LSB +: 3] = s_q.irq_level;
                        s_d.prdata[`IRQ_VECTOR_LSB +: 9] = s_q.irq_vec_cfg;
                    end
                    `CTRL_IRQ_STATUS: begin
                        s_d.prdata[1:0] = s_q.irq_status;
                        s_d.prdata[`STAT_EXEC_CART_BIT] =
                            s_q.exec == disk_arb_pkg::EX_CART;
                        s_d.prdata[`STAT_EXEC_FLOP_BIT] =
                            s_q.exec == disk_arb_pkg::EX_FLOP;
                        s_d.prdata[`STAT_QUEUE_BIT] = s_q.qvalid;
                    end
                    `CTRL_IRQ_ENABLE: s_d.prdata = {30'h0, s_q.irq_en};
                    default: s_d.prdata = 32'h0000_0000;
                endcase
            end
        end
        if (access && pwrite && !s_q.pslverr) begin
            if (dec_kind == 2'b01 && !is_csr) begin
                s_d.ram[dec_idx] = pwdata[15:0];
            end else if (is_csr) begin
                // Flag bits are hardware owned; a command always clears it
                wval = pwdata[15:0];
                wval[`CART_READY_BIT] = s_d.ram[dec_idx][`CART_READY_BIT];
                wval[`FLOP_DONE_BIT] = s_d.ram[dec_idx][`FLOP_DONE_BIT];
                wval[flag_of(csr_floppy)] = 1'b0;
                s_d.ram[dec_idx] = wval;
                if (s_d.exec == disk_arb_pkg::EX_IDLE) begin
                    s_d.exec = csr_floppy ? disk_arb_pkg::EX_FLOP
                                          : disk_arb_pkg::EX_CART;
                    s_d.cmd_valid = 1'b1;
                    s_d.cmd_floppy = csr_floppy;
                    s_d.cmd_word = wval;
                end else begin
                    s_d.qvalid = 1'b1;
                    s_d.qfloppy = csr_floppy;
                    s_d.qword = wval;
                end
            end else if (dec_kind == 2'b10) begin
                unique case (dec_idx[2:0])
                    `CTRL_CART_BASE: s_d.cart_base = pwdata[4:0];
                    `CTRL_FLOP_BASE: s_d.flop_base = pwdata[4:0];
                    `CTRL_BOOT_BASE: s_d.boot_base = pwdata[4:0];
                    `CTRL_IRQ_CFG: begin
                        s_d.irq_level = pwdata[`IRQ_LEVEL_LSB +: 3];
                        s_d.irq_vec_cfg = pwdata[`IRQ_VECTOR_LSB +: 9];
                    end
                    `CTRL_IRQ_CLEAR: irq_clr = pwdata[1:0];
                    `CTRL_IRQ_ENABLE: s_d.irq_en = pwdata[1:0];
                    default: irq_clr = 2'b00;
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        s_d.irq_status = (s_q.irq_status & ~irq_clr) | irq_set;
        s_d.irq = |(s_d.irq_status & s_d.irq_en);
        if (irq_ack) begin
            s_d.irq_vector = s_q.irq_vec_cfg;
        end
        s_d.dbus_ready = !s_d.hold_full &&
                         s_d.exec != disk_arb_pkg::EX_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ram[`CART_CSR_IDX][`CART_READY_BIT] <= 1'b1;
            s_q.ram[`FLOP_CSR_IDX][`FLOP_DONE_BIT] <= 1'b1;
            s_q.exec <= disk_arb_pkg::EX_IDLE;
            s_q.xfer <= disk_arb_pkg::XF_IDLE;
            s_q.wptr <= `WPTR_FIRST;
            s_q.cart_base <= `CART_BASE_RST;
            s_q.flop_base <= `FLOP_BASE_RST;
            s_q.boot_base <= `BOOT_BASE_RST;
            s_q.irq_level <= `IRQ_LEVEL_RST;
            s_q.irq_vec_cfg <= `IRQ_VECTOR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign cmd_valid = s_q.cmd_valid;
    assign cmd_floppy = s_q.cmd_floppy;
    assign cmd_word = s_q.cmd_word;
    assign dbus_ready = s_q.dbus_ready;
    assign irq = s_q.irq;
    assign irq_level = s_q.irq_level;
    assign irq_vector = s_q.irq_vector;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb_sys @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_one_exec;
        $rose(s_q.cmd_valid) |->
            $past(s_q.exec) == disk_arb_pkg::EX_IDLE || $past(ctrl_done);
    endproperty
    a_one_exec: assert property (p_one_exec)
        else $error("command forwarded while another was running");

    property p_idle_floppy;
        access && pwrite && is_csr && csr_floppy && !s_q.pslverr &&
        s_q.exec == disk_arb_pkg::EX_IDLE |=>
            s_q.exec == disk_arb_pkg::EX_FLOP && s_q.cmd_valid &&
            !s_q.ram[`FLOP_CSR_IDX][`FLOP_DONE_BIT];
    endproperty
    a_idle_floppy: assert property (p_idle_floppy)
        else $error("idle floppy command not forwarded");

    property p_queue_cart;
        access && pwrite && is_csr && !csr_floppy && !s_q.pslverr &&
        !ctrl_done && s_q.exec == disk_arb_pkg::EX_FLOP |=>
            s_q.qvalid && !s_q.qfloppy &&
            !s_q.ram[`CART_CSR_IDX][`CART_READY_BIT];
    endproperty
    a_queue_cart: assert property (p_queue_cart)
        else $error("cartridge command not queued");

    property p_floppy_done;
        ctrl_done && s_q.exec == disk_arb_pkg::EX_FLOP && s_q.qvalid |=>
            s_q.ram[`FLOP_CSR_IDX][`FLOP_DONE_BIT] &&
            s_q.exec == disk_arb_pkg::EX_CART && s_q.cmd_valid;
    endproperty
    a_floppy_done: assert property (p_floppy_done)
        else $error("queued cartridge command not started");

    property p_queue_floppy;
        access && pwrite && is_csr && csr_floppy && !s_q.pslverr &&
        !ctrl_done && s_q.exec == disk_arb_pkg::EX_CART |=>
            s_q.qvalid && s_q.qfloppy &&
            !s_q.ram[`FLOP_CSR_IDX][`FLOP_DONE_BIT];
    endproperty
    a_queue_floppy: assert property (p_queue_floppy)
        else $error("floppy command not queued");

    property p_cart_done;
        ctrl_done && s_q.exec == disk_arb_pkg::EX_CART && !s_q.qvalid &&
        !access |=>
            s_q.ram[`CART_CSR_IDX][`CART_READY_BIT] &&
            s_q.exec == disk_arb_pkg::EX_IDLE;
    endproperty
    a_cart_done: assert property (p_cart_done)
        else $error("cartridge completion mishandled");

    property p_irq_gate;
        ctrl_done && s_q.exec == disk_arb_pkg::EX_CART |=>
            s_q.irq_status[`IRQ_CART] ==
            $past(s_q.ram[`CART_CSR_IDX][`IRQ_ENABLE_BIT] ||
                  s_q.irq_status[`IRQ_CART]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("completion interrupt not gated by enable");

    property p_refuse;
        setup && pwrite && is_csr && busy_for |=> s_q.pslverr ##1
            s_q.qword == $past(s_q.qword, 2);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("command taken while busy");

    property p_word_path;
        s_q.xfer == disk_arb_pkg::XF_IDLE && s_q.hold_full |=>
            s_q.xfer == disk_arb_pkg::XF_SHIFT [*4] ##1
            s_q.xfer == disk_arb_pkg::XF_STORE && a_word == $past(b_word, 4);
    endproperty
    a_word_path: assert property (p_word_path)
        else $error("buffered word not moved by four nibble shifts");

    property p_vector;
        irq_ack |=> irq_vector == $past(s_q.irq_vec_cfg);
    endproperty
    a_vector: assert property (p_vector)
        else $error("wrong vector on acknowledge");
endmodule : dual_disk_command_arbiter

// >>> verification/disk_ctrl_model.sv
/*
 * Shared disk controller model: takes one command, sends one data word,
 * reports completion DELAY+1 cycles later. Assumes one clock with the DUT.
 */
`timescale 1ns/1ps
module disk_ctrl_model #(
    parameter int DELAY = 30,
    parameter logic [15:0] WORD = 16'h5a3c
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_floppy,
    output logic cmd_ready,
    output logic ctrl_done,
    output logic dbus_valid,
    output logic [15:0] dbus_word,
    input wire logic dbus_ready,
    output logic busy_q,
    output logic overlap_q,
    output logic floppy_q
);
    int cnt_q;
    assign cmd_ready = !busy_q;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            overlap_q <= 1'b0;
            floppy_q <= 1'b0;
            ctrl_done <= 1'b0;
            dbus_valid <= 1'b0;
            dbus_word <= ~WORD;
            cnt_q <= 0;
        end else begin
            ctrl_done <= 1'b0;
            // A request while busy means two commands in flight
            if (busy_q && cmd_valid) overlap_q <= 1'b1;
            // Released data line shows a changed value, not the old word
            if (dbus_valid && dbus_ready) begin
                dbus_valid <= 1'b0;
                dbus_word <= ~dbus_word;
            end
            if (!busy_q && cmd_valid) begin
                busy_q <= 1'b1;
                cnt_q <= DELAY;
                floppy_q <= cmd_floppy;
                dbus_valid <= 1'b1;
                dbus_word <= WORD ^ {15'h0, cmd_floppy};
            end else if (busy_q && cnt_q == 0) begin
                busy_q <= 1'b0;
                ctrl_done <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : disk_ctrl_model

// >>> verification/tb.sv
/*
 * Self-checking bench of the dual disk command arbiter over APB.
 * Assumes the controller model beside it; APB waits for pready.
 */
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, irq_ack = 1'b0, pready, pslverr, cv, cr, cf;
    logic dn, dv, dr, irq, busy, ovl, flp, er;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] cw, dw;
    logic [2:0] irq_level;
    logic [8:0] irq_vector;
    int error_cnt = 0, checks_done = 0;
    always #4 sys_clk = ~sys_clk;
    dual_disk_command_arbiter dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cv), .cmd_ready(cr),
        .cmd_floppy(cf), .cmd_word(cw), .ctrl_done(dn), .dbus_valid(dv),
        .dbus_word(dw), .dbus_ready(dr), .irq(irq), .irq_level(irq_level),
        .irq_ack(irq_ack), .irq_vector(irq_vector));
    disk_ctrl_model ctl (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cv),
        .cmd_floppy(cf), .cmd_ready(cr), .ctrl_done(dn), .dbus_valid(dv),
        .dbus_word(dw), .dbus_ready(dr), .busy_q(busy), .overlap_q(ovl),
        .floppy_q(flp));
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wait_done();
        int n;
        n = 0;
        while (dn !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) error_cnt++;
        step(3);
    endtask : wait_done
    task automatic t_reset();
        apb(0, 12'h040, 0);
        check("cart", rd, 32'h80);
        apb(0, 12'h080, 0);
        check("flop", rd, 32'h20);
        apb(0, 12'h80c, 0);
        check("cfg", rd, 32'h0070_0004);
        check("lvl", {29'h0, irq_level}, 32'h4);
        apb(0, 12'h81c, 0);
        check("unmap", {31'h0, er}, 1);
        apb(1, 12'h0dc, 32'h1234);
        apb(0, 12'h0dc, 0);
        check("boot", rd, 32'h1234);
        apb(1, 12'h800, 32'h5);
        apb(1, 12'h804, 32'h6);
        apb(0, 12'h140, 0);
        check("moved", rd, 32'h80);
        apb(0, 12'h180, 0);
        check("fmoved", rd, 32'h20);
        apb(1, 12'h800, 32'h1);
        apb(1, 12'h804, 32'h2);
        $display("test reset done");
    endtask : t_reset
    task automatic t_flop_cart();
        apb(1, 12'h818, 32'h3);
        apb(1, 12'h080, 32'h40);
        apb(0, 12'h080, 0);
        check("fdone", rd & 32'h20, 0);
        check("fwd", {31'h0, flp}, 1);
        check("cmd", {16'h0, cw}, 32'h40);
        apb(1, 12'h040, 32'h40);
        apb(0, 12'h040, 0);
        check("cartridge_ready_flag", rd & 32'h80, 0);
        apb(0, 12'h810, 0);
        check("q", rd & 32'h700, 32'h600);
        apb(1, 12'h080, 32'h40);
        check("ref_f", {31'h0, er}, 1);
        apb(1, 12'h040, 32'h40);
        check("ref_c", {31'h0, er}, 1);
        wait_done();
        apb(0, 12'h080, 0);
        check("fdone", rd & 32'h20, 32'h20);
        check("fwd", {31'h0, flp}, 0);
        apb(0, 12'h084, 0);
        check("word", rd, 32'h5a3d);
        wait_done();
        apb(0, 12'h040, 0);
        check("cartridge_ready_flag", rd & 32'h80, 32'h80);
        apb(0, 12'h810, 0);
        check("st", rd & 32'h703, 32'h3);
        check("irq", {31'h0, irq}, 1);
        apb(1, 12'h814, 32'h3);
        step(1);
        check("irq", {31'h0, irq}, 0);
        $display("test floppy first done");
    endtask : t_flop_cart
    task automatic t_cart_flop();
        apb(1, 12'h040, 32'h0);
        apb(1, 12'h080, 32'h0);
        apb(0, 12'h080, 0);
        check("fdone", rd & 32'h20, 0);
        check("fwd", {31'h0, flp}, 0);
        wait_done();
        apb(0, 12'h040, 0);
        check("cartridge_ready_flag", rd & 32'h80, 32'h80);
        check("fwd", {31'h0, flp}, 1);
        apb(0, 12'h044, 0);
        check("word", rd, 32'h5a3c);
        wait_done();
        apb(0, 12'h810, 0);
        check("st", rd & 32'h703, 0);
        check("ovl", {31'h0, ovl}, 0);
        check("idle", {31'h0, busy}, 0);
        $display("test cartridge first done");
    endtask : t_cart_flop
    task automatic t_irq();
        apb(1, 12'h80c, 32'h0123_0005);
        check("lvl", {29'h0, irq_level}, 32'h5);
        apb(1, 12'h818, 32'h1);
        apb(1, 12'h040, 32'h40);
        wait_done();
        check("irq", {31'h0, irq}, 1);
        apb(1, 12'h818, 32'h0);
        step(1);
        check("mask", {31'h0, irq}, 0);
        irq_ack <= 1'b1;
        step(1);
        irq_ack <= 1'b0;
        step(2);
        check("vec", {23'h0, irq_vector}, 32'h123);
        $display("test interrupt done");
    endtask : t_irq
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        step(6);
        rst_n <= 1'b1;
        step(1);
        t_reset();
        t_flop_cart();
        t_cart_flop();
        t_irq();
        print_verdict();
    end
    initial begin
        step(5000);
        error_cnt++;
        print_verdict();
    end
endmodule : tb
